/* core/lsd_core.sv */
// Purpose: serial-loaded control of 16 LED sink channels with diagnostics
// Assumes: serial pins synchronous to core_clk, serial clock well below it
// Notes: error mode entered through the control register
`timescale 1ns/10ps
module lsd_core
  import lsd_pkg::*;
(
  input wire logic core_clk, // 200 MHz clock
  input wire logic rst_b, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic serial_clk, // Host serial clock
  input wire logic serial_in, // Serial data in
  input wire logic load_strobe, // Load strobe
  input wire logic drive_gate_n, // Driver gate, low on
  input wire lsd_pkg::lsd_diag_s sense, // Channel sense results
  output logic serial_out, // Serial data out
  output logic [lsd_pkg::CH_N-1:0] led_sink_channels, // Sink enables
  output logic low_current, // Reduced drive request
  input wire lsd_pkg::lsd_bus_s bus, // Register request
  output logic [lsd_pkg::DATA_W-1:0] rdata, // Read data
  output logic irq // Interrupt level
);
  // ***********************
  // Edge detection
  // ***********************
  logic sck_rise;
  logic sck_fall;
  logic ld_rise;

  lsd_edge u_sck (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin(serial_clk),
    .rise(sck_rise),
    .fall(sck_fall)
  );

  lsd_edge u_ld (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ce(ce),
    .pin(load_strobe),
    .rise(ld_rise),
    .fall()
  );

  // ***********************
  // Serial path and display
  // ***********************
  logic [CH_N-1:0] shift_q;
  logic [CH_N-1:0] display;
  logic [CH_N-1:0] led_q;
  logic so_q;
  lsd_mode_e mode;
  lsd_diag_s result;
  logic glob;
  logic [DATA_W-1:0] ctrl;
  logic [CH_N-1:0] next_shift;
  logic [CH_N-1:0] next_display;
  logic [CH_N-1:0] next_led;
  logic next_so;
  lsd_mode_e next_mode;
  lsd_diag_s next_result;
  logic next_glob;
  logic diag_on;
  logic load_fault;

  assign diag_on = ctrl[CTRL_DIAG_EN];
  // Only lit channels can report open or short
  assign load_fault = (|(sense.open_ch & display)) | (|(sense.short_ch & display)) | sense.hot;

  always_comb
  begin
    next_shift = shift_q;
    next_display = display;
    next_mode = mode;
    next_result = result;
    next_glob = glob;
    next_so = so_q;
    if (sck_rise && mode == LSD_NORMAL)
      next_shift = {shift_q[CH_N-2:0], serial_in};
    if (!ctrl[CTRL_ERR_EN])
      next_mode = LSD_NORMAL;
    else
    begin
      unique case (mode)
        LSD_NORMAL: next_mode = LSD_GLOBAL;
        LSD_GLOBAL: next_mode = sck_rise ? LSD_OPEN : mode;
        LSD_OPEN: next_mode = sck_rise ? LSD_SHORT : mode;
        LSD_SHORT: next_mode = sck_rise ? LSD_TEMP : mode;
        LSD_TEMP: next_mode = sck_rise ? LSD_GLOBAL : mode;
        default: next_mode = LSD_NORMAL;
      endcase
    end
    if (ld_rise)
      next_display = shift_q;
    if (ld_rise && diag_on)
    begin
      next_result.open_ch = sense.open_ch & display;
      next_result.short_ch = sense.short_ch & display;
      next_result.hot = sense.hot;
      next_glob = load_fault;
    end
    if (ce)
    begin
      unique case (mode)
        LSD_NORMAL: next_so = sck_fall ? shift_q[SO_TAP] : so_q;
        LSD_GLOBAL: next_so = ~glob;
        LSD_OPEN: next_so = ~(|result.open_ch);
        LSD_SHORT: next_so = ~(|result.short_ch);
        LSD_TEMP: next_so = ~result.hot;
        default: next_so = 1'b1;
      endcase
    end
    next_led = led_q;
    if (ce)
      next_led = drive_gate_n ? CH_ZERO : display;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_q <= CH_ZERO;
      display <= CH_ZERO;
      led_q <= CH_ZERO;
      so_q <= 1'b1;
      mode <= LSD_NORMAL;
      result <= '0;
      glob <= 1'b0;
    end
    else if (ce)
    begin
      shift_q <= next_shift;
      display <= next_display;
      led_q <= next_led;
      so_q <= next_so;
      mode <= next_mode;
      result <= next_result;
      glob <= next_glob;
    end
  end

  // in normal mode the tap stage feeds the next device in chain; error modes send fault flags
  assign serial_out = so_q;
  assign led_sink_channels = led_q;
  assign low_current = ctrl[CTRL_LOW_CUR] & (diag_on | mode != LSD_NORMAL);

  // ***********************
  // Register port and interrupt
  // ***********************
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] next_ctrl;
  logic [ST_W-1:0] next_status;
  logic [ST_W-1:0] next_mask;
  logic [DATA_W-1:0] next_rdata;
  logic [ST_W-1:0] events;

  always_comb
  begin
    events = '0;
    events[ST_LOAD] = ld_rise;
    events[ST_FAULT] = ld_rise & diag_on & load_fault;
    events[ST_HOT] = ld_rise & diag_on & sense.hot;
    next_ctrl = ctrl;
    next_mask = mask;
    next_status = status;
    if (bus.wr && bus.addr == REG_CTRL)
      next_ctrl = bus.wdata;
    if (bus.wr && bus.addr == REG_MASK)
      next_mask = bus.wdata[ST_W-1:0];
    if (bus.wr && bus.addr == REG_STATUS)
      next_status = status & ~bus.wdata[ST_W-1:0];
    // Set wins over a same-cycle clear
    next_status = next_status | events;
    next_rdata = RD_ZERO;
    if (bus.rd)
    begin
      unique case (bus.addr)
        REG_CTRL: next_rdata = ctrl;
        REG_STATUS: next_rdata = lsd_pad_st(status);
        REG_MASK: next_rdata = lsd_pad_st(mask);
        REG_DISPLAY: next_rdata = display;
        REG_OPEN: next_rdata = result.open_ch;
        REG_SHORT: next_rdata = result.short_ch;
        REG_MODE: next_rdata = {{(DATA_W-5){1'b0}}, result.hot, glob, mode};
        REG_SHIFT: next_rdata = shift_q;
        default: next_rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= CTRL_RST;
      status <= ST_RST;
      mask <= MASK_RST;
      rdata_q <= RD_ZERO;
    end
    else if (ce)
    begin
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      rdata_q <= next_rdata;
    end
  end

  assign rdata = rdata_q;
  assign irq = |(status & mask);

  // ***********************
  // Assertions
  // ***********************
  shift_on_rise_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    sck_rise && mode == LSD_NORMAL |=> shift_q == {$past(shift_q[CH_N-2:0]), $past(serial_in)})
    else $error("shift register did not take serial_in");

  err_no_shift_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    sck_rise && mode == LSD_GLOBAL && ctrl[CTRL_ERR_EN] |=> $stable(shift_q) && mode == LSD_OPEN)
    else $error("error mode did not step or data shifted");

  gate_off_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && drive_gate_n |=> led_sink_channels == CH_ZERO)
    else $error("drivers on while gate high");

  so_tap_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    sck_fall && mode == LSD_NORMAL |=> serial_out == $past(shift_q[SO_TAP]))
    else $error("serial_out not from tap stage");

  global_out_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && mode == LSD_GLOBAL ##1 mode == LSD_GLOBAL |-> serial_out == ~$past(glob))
    else $error("global fault polarity wrong");

  load_copy_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ld_rise |=> display == $past(shift_q))
    else $error("load did not copy shift register");

  data_hold_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    !ld_rise |=> $stable(display))
    else $error("display changed without load");

  chan_map_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && !drive_gate_n |=> led_sink_channels == $past(display))
    else $error("channel does not follow its data bit");

  fault_cap_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ld_rise && diag_on |=> glob == $past(load_fault) && (status[ST_FAULT] || !$past(load_fault)))
    else $error("global fault not captured at load");

  load_seen_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ld_rise |=> status[ST_LOAD])
    else $error("load event not recorded");

  open_cap_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ld_rise && diag_on |=> result.open_ch == ($past(sense.open_ch) & $past(display)))
    else $error("open sense not captured on lit channels");

  hot_cap_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ld_rise && diag_on |=> result.hot == $past(sense.hot))
    else $error("temperature result not kept");

  open_read_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    ce && bus.rd && bus.addr == REG_OPEN |=> rdata == $past(result.open_ch))
    else $error("open result not read back");

  ce_freeze_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    !ce |=> $stable(display) && $stable(status) && $stable(mode))
    else $error("state moved while clock enable low");

  low_cur_a : assert property (@(posedge core_clk) disable iff (!rst_b)
    low_current |-> ctrl[CTRL_LOW_CUR])
    else $error("low current without request");
endmodule : lsd_core

/* core/lsd_pkg.sv */
// Purpose: shared constants and types of the serial LED sink core
// Assumes: one clock, core_clk at 200 MHz; serial pins synchronous to it
// Notes: register indices are word addresses on the plain register port
package lsd_pkg;
  localparam int CH_N = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Shift stage shown on serial_out half a serial period after its edge
  localparam int SO_TAP = 8;

  // ***********************
  // Register indices
  // ***********************
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] REG_DISPLAY = 4'h3;
  localparam logic [ADDR_W-1:0] REG_OPEN = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SHORT = 4'h5;
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_SHIFT = 4'h7;

  // Control bits
  localparam int CTRL_ERR_EN = 0;
  localparam int CTRL_DIAG_EN = 1;
  localparam int CTRL_LOW_CUR = 2;
  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;

  // Status and mask bits
  localparam int ST_LOAD = 0;
  localparam int ST_FAULT = 1;
  localparam int ST_HOT = 2;
  localparam int ST_W = 3;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  localparam logic [CH_N-1:0] CH_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] RD_ZERO = 16'h0000;

  // Error modes, Gray stepped along the usual walk except the TEMP to GLOBAL wrap, which flips three bits
  typedef enum logic [2:0] {
    LSD_NORMAL = 3'h0,
    LSD_GLOBAL = 3'h1,
    LSD_OPEN = 3'h3,
    LSD_SHORT = 3'h2,
    LSD_TEMP = 3'h6
  } lsd_mode_e;

  typedef struct packed {
    logic [CH_N-1:0] open_ch;
    logic [CH_N-1:0] short_ch;
    logic hot;
  } lsd_diag_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lsd_bus_s;

  function automatic logic [DATA_W-1:0] lsd_pad_st(input logic [ST_W-1:0] v);
    lsd_pad_st = {{(DATA_W-ST_W){1'b0}}, v};
  endfunction : lsd_pad_st
endpackage : lsd_pkg

/* core/lsd_edge.sv */
// Purpose: rising and falling edge pulses of a sampled pin
// Assumes: pin already synchronous to core_clk
// Notes: pulses are suppressed while the clock enable is low
`timescale 1ns/10ps
module lsd_edge
  import lsd_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst_b, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic pin, // Sampled pin
  output logic rise, // One-cycle rise pulse
  output logic fall // One-cycle fall pulse
);
  logic prev;
  logic next_prev;

  always_comb
  begin
    next_prev = ce ? pin : prev;
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      prev <= 1'b0;
    else
      prev <= next_prev;
  end

  assign rise = ce & pin & ~prev;
  assign fall = ce & ~pin & prev;
endmodule : lsd_edge

/* verification/lsd_host_model.sv */
// Purpose: host controller model on the serial pins of the LED sink core
// Assumes: ce held high; pins change just after a core_clk rise
// Notes: serial clock rests low between frames; released data shows its inverse
`timescale 1ns/10ps
module lsd_host_model
(
  input wire logic core_clk, // Core clock
  output logic serial_clk, // Serial clock to core
  output logic serial_in, // Serial data to core
  output logic load_strobe // Load strobe to core
);
  initial
  begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
  end

  task automatic clock_bit(input logic b);
    @(posedge core_clk);
    serial_in <= b;
    serial_clk <= 1'b1;
    repeat (2) @(posedge core_clk);
    serial_clk <= 1'b0;
    serial_in <= ~b;
    repeat (2) @(posedge core_clk);
  endtask : clock_bit

  task automatic shift_word(input logic [15:0] v);
    for (int i = 15; i >= 0; i--)
      clock_bit(v[i]);
  endtask : shift_word

  task automatic pulse_load();
    @(posedge core_clk);
    load_strobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    load_strobe <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : pulse_load
endmodule : lsd_host_model

/* verification/lsd_core_tb_top.sv */
// Purpose: self-checking bench of the serial LED sink core
// Assumes: 200 MHz core_clk, ce high except one freeze check
// Notes: open and short faults only count on channels lit before the load
`timescale 1ns/10ps
module lsd_core_tb_top;
  import lsd_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic drive_gate_n = 1'b0;
  logic ce = 1'b1;
  logic serial_clk, serial_in, load_strobe, serial_out, low_current, irq;
  logic [CH_N-1:0] led_sink_channels;
  logic [DATA_W-1:0] rdata;
  lsd_diag_s sense = '0;
  lsd_bus_s bus = '0;
  int fails = 0;
  int checks = 0;
  localparam logic [15:0] pat = 16'ha5c3;
  // Mode register after each step: open, short, temp, global
  logic [15:0] steps [4] = '{16'h000b, 16'h000a, 16'h000e, 16'h0009};
  logic [3:0] outs = 4'b0100;

  always #2.5 core_clk = ~core_clk;

  lsd_core i_lsd_core (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .serial_clk(serial_clk),
    .serial_in(serial_in), .load_strobe(load_strobe), .drive_gate_n(drive_gate_n), .sense(sense),
    .serial_out(serial_out), .led_sink_channels(led_sink_channels), .low_current(low_current),
    .bus(bus), .rdata(rdata), .irq(irq));
  lsd_host_model i_lsd_host_model (.core_clk(core_clk), .serial_clk(serial_clk),
    .serial_in(serial_in), .load_strobe(load_strobe));

  // ***********************
  // Tasks
  // ***********************
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk16

  task automatic chk1(input logic g, input logic e);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    bus <= {a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge core_clk);
    bus <= {a, 16'h0000, 1'b0, 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1;
    chk16(rdata, e);
  endtask : rd_chk

  task automatic close_out();
    if (fails == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ***********************
  // Tests
  // ***********************
  initial
  begin
    #60000;
    fails++;
    close_out();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    tick(2);
    rd_chk(REG_CTRL, 16'h0000);
    wr_reg(4'h9, 16'hffff);
    rd_chk(4'h9, 16'h0000);
    i_lsd_host_model.shift_word(pat);
    tick(3);
    rd_chk(REG_SHIFT, pat);
    chk16(led_sink_channels, CH_ZERO);
    chk1(serial_out, pat[8]);
    i_lsd_host_model.pulse_load();
    tick(3);
    rd_chk(REG_DISPLAY, pat);
    chk16(led_sink_channels, pat);
    @(posedge core_clk) drive_gate_n <= 1'b1;
    tick(3);
    chk16(led_sink_channels, CH_ZERO);
    @(posedge core_clk) drive_gate_n <= 1'b0;
    rd_chk(REG_STATUS, 16'h0001);
    chk1(irq, 1'b0);
    wr_reg(REG_MASK, 16'h0001);
    tick(2);
    chk1(irq, 1'b1);
    wr_reg(REG_STATUS, 16'h0001);
    tick(2);
    chk1(irq, 1'b0);
    rd_chk(REG_STATUS, 16'h0000);
    // Faults on unlit channels 2 and 4 must be ignored
    wr_reg(REG_CTRL, 16'h0002);
    @(posedge core_clk) sense <= {16'h0104, 16'h0012, 1'b0};
    i_lsd_host_model.shift_word(16'h00ff);
    i_lsd_host_model.pulse_load();
    tick(3);
    rd_chk(REG_OPEN, 16'h0100);
    rd_chk(REG_SHORT, 16'h0002);
    rd_chk(REG_STATUS, 16'h0003);
    rd_chk(REG_MODE, 16'h0008);
    wr_reg(REG_CTRL, 16'h0007);
    tick(3);
    chk1(serial_out, 1'b0);
    chk1(low_current, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      i_lsd_host_model.clock_bit(1'b1);
      tick(3);
      rd_chk(REG_MODE, steps[k]);
      chk1(serial_out, outs[k]);
    end
    rd_chk(REG_SHIFT, 16'h00ff);
    wr_reg(REG_CTRL, 16'h0004);
    tick(2);
    chk1(low_current, 1'b0);
    rd_chk(REG_MODE, 16'h0008);
    // Clock enable low must block a write to the status register
    @(posedge core_clk) ce <= 1'b0;
    wr_reg(REG_STATUS, 16'h0007);
    @(posedge core_clk) ce <= 1'b1;
    tick(1);
    chk1(irq, 1'b1);
    rd_chk(REG_STATUS, 16'h0003);
    close_out();
  end
endmodule : lsd_core_tb_top
